/* File: src/usri_core.sv */
// Serial transceiver register layer with simple shifters behind it
// What this block does
// - One data address: write to tx, read rx
// - Short characters: tx ignores, rx zeroes upper bits
// - Data write ignored while empty flag clear
// - Enabled transmitter loads shifter, sends on pin
// - Receive buffer is two-entry FIFO, advances on read
// - Receive-complete high while unread data exists
// - Transmit-complete sets when all sent; write-one clears
// - Data-empty flag set when buffer free, reset set
// - Framing error follows head character; write zero
// - Overrun when FIFO, shifter full, new start
// - Parity error flag for head when checked
// - Double speed divides by 8 instead of 16
// - Multiprocessor filter drops non-address frames
// - Interrupt needs enable, global enable and flag
// - Receiver owns pin; disable flushes buffer, errors
// - Transmitter disable waits until idle, releases pin
// - Size code split over control B and C
// - Biphase mode disables filter and size bits
// - Size codes 5,6,7,8 and 9 bits
// - Parity 00 off, 10 even, 11 odd
// - Stop select gives one or two stop bits
// - Frame-type bit one marks address frame
`timescale 1ns/10ps
module usri_core
  import usri_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // System controls
  input wire logic i_global_irq_en,
  input wire logic i_biphase_mode,
  input wire logic i_baud_tick,
  input wire logic i_txc_irq_ack,
  // Serial line
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_rxd_owned,
  // Interrupt requests
  output logic o_rxc_irq,
  output logic o_txc_irq,
  output logic o_data_register_empty_flag_irq
);
  logic [7:0] ctrl_b;
  logic [7:0] ctrl_c;
  logic dbl_speed;
  logic mp_filter;
  logic txc_flag;
  // Transmit side
  logic tx_buf_full;
  logic [8:0] tx_buf;
  logic [11:0] tx_shift;
  logic [3:0] tx_bits;
  logic [4:0] tx_div;
  logic tx_drive;
  usri_tx_state_t tx_state;
  // Receive FIFO, entries: {fe, pe, ninth, data}
  logic [10:0] rx_fifo [0:1];
  logic [1:0] rx_count;
  logic rx_rd_ptr;
  logic dor_flag;
  logic rx_hold_full;
  logic [10:0] rx_hold;
  // Receiver shifter
  logic rx_s1, rx_s2, rx_prev;
  logic rx_busy;
  logic [4:0] rx_div;
  logic [3:0] rx_bitn;
  logic [10:0] rx_sh;
  logic [4:0] ovs;
  logic [2:0] csz;
  logic [3:0] nbits;
  logic par_en;
  logic wr_data, rd_data, wr_a;
  logic tx_load, tx_done, rx_push, rx_start;
  logic [10:0] rx_word;

  // Character width from split size code; biphase forces eight bits
  function automatic logic [3:0] char_bits(input logic [2:0] code, input logic bi);
    if (bi) begin
      char_bits = 4'h8;
    end else begin
      case (code)
        3'h0: char_bits = 4'h5;
        3'h1: char_bits = 4'h6;
        3'h2: char_bits = 4'h7;
        CSZ_NINE: char_bits = 4'h9;
        default: char_bits = 4'h8;
      endcase
    end
  endfunction : char_bits

  // Keep only the low n data bits
  function automatic logic [8:0] mask_bits(input logic [8:0] d, input logic [3:0] n);
    mask_bits = d & ((9'h001 << n) - 9'h001);
  endfunction : mask_bits

  assign csz = {ctrl_b[B_CSZ2], ctrl_c[C_CSZ1], ctrl_c[C_CSZ0]};
  assign nbits = char_bits(csz, i_biphase_mode);
  assign par_en = ctrl_c[C_PM1];
  assign ovs = dbl_speed ? OVS_DOUBLE : OVS_NORMAL;
  assign wr_data = i_wr && (i_addr == ADDR_DATA);
  assign rd_data = i_rd && (i_addr == ADDR_DATA);
  assign wr_a = i_wr && (i_addr == ADDR_CTRL_A);
  assign tx_load = ctrl_b[B_TRANSMITTER_ENABLE] && tx_buf_full && (tx_state == USRI_TX_IDLE);
  assign tx_done = (tx_state == USRI_TX_SHIFT) && i_baud_tick && (tx_div == ovs - 5'h01)
    && (tx_bits == 4'h1);

  // Control registers B and C plus writable bits of A
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_b <= RST_CTRL_B;
      ctrl_c <= RST_CTRL_C;
      dbl_speed <= 1'b0;
      mp_filter <= 1'b0;
    end else begin
      if (i_wr && i_addr == ADDR_CTRL_B) begin
        ctrl_b <= {i_wdata[7:2], 1'b0, i_wdata[B_TX8]};
      end
      if (i_wr && i_addr == ADDR_CTRL_C) begin
        ctrl_c <= i_wdata & WMASK_CTRL_C;
      end
      if (wr_a) begin
        dbl_speed <= i_wdata[A_DBL];
        mp_filter <= i_wdata[A_MPF];
      end
    end
  end

  // Transmit buffer, accepted only while empty
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_buf_full <= 1'b0;
      tx_buf <= 9'h000;
    end else if (wr_data && !tx_buf_full) begin
      tx_buf_full <= 1'b1;
      tx_buf <= mask_bits({ctrl_b[B_TX8], i_wdata}, nbits);
    end else if (tx_load) begin
      tx_buf_full <= 1'b0;
    end
  end

  // Transmit shifter: start, data, parity, stops
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_state <= USRI_TX_IDLE;
      tx_shift <= 12'hFFF;
      tx_bits <= 4'h0;
      tx_div <= 5'h00;
    end else begin
      case (tx_state)
        USRI_TX_IDLE: begin
          if (tx_load) begin
            tx_state <= USRI_TX_SHIFT;
            tx_shift <= ({3'h7, tx_buf} | (12'hFFF << nbits)) << 1;
            if (par_en) begin
              tx_shift[nbits + 4'h1] <= ^tx_buf ^ ctrl_c[C_PM0];
            end
            tx_bits <= nbits + 4'h2 + {3'h0, par_en} + {3'h0, ctrl_c[C_SBS]};
            tx_div <= 5'h00;
          end
        end
        USRI_TX_SHIFT: begin
          if (i_baud_tick) begin
            if (tx_div == ovs - 5'h01) begin
              tx_div <= 5'h00;
              tx_shift <= {1'b1, tx_shift[11:1]};
              tx_bits <= tx_bits - 4'h1;
              if (tx_bits == 4'h1) begin
                tx_state <= USRI_TX_IDLE;
              end
            end else begin
              tx_div <= tx_div + 5'h01;
            end
          end
        end
        default: tx_state <= USRI_TX_IDLE;
      endcase
    end
  end

  // Transmit complete flag; set beats clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      txc_flag <= 1'b0;
    end else if (tx_done && !tx_buf_full) begin
      txc_flag <= 1'b1;
    end else if ((wr_a && i_wdata[A_TXC]) || i_txc_irq_ack) begin
      txc_flag <= 1'b0;
    end
  end

  // Pin ownership; transmitter release waits for idle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_drive <= 1'b0;
      o_txd <= 1'b1;
      o_rxd_owned <= 1'b0;
    end else begin
      if (ctrl_b[B_TRANSMITTER_ENABLE]) begin
        tx_drive <= 1'b1;
      end else if (tx_state == USRI_TX_IDLE && !tx_buf_full) begin
        tx_drive <= 1'b0;
      end
      o_txd <= (tx_state == USRI_TX_SHIFT) ? tx_shift[0] : 1'b1;
      o_rxd_owned <= ctrl_b[B_RECEIVER_ENABLE];
    end
  end
  assign o_txd_oe = tx_drive;

  // Receive pin synchroniser
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= i_rxd;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end
  assign rx_start = ctrl_b[B_RECEIVER_ENABLE] && !rx_busy && rx_prev && !rx_s2;

  // Receive shifter, samples each bit in its first cycle, one bit time after the start edge; frame = data, parity, stop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !ctrl_b[B_RECEIVER_ENABLE]) begin
      rx_busy <= 1'b0;
      rx_div <= 5'h00;
      rx_bitn <= 4'h0;
      rx_sh <= 11'h000;
    end else if (rx_start) begin
      rx_busy <= 1'b1;
      rx_div <= 5'h00;
      rx_bitn <= 4'h0;
    end else if (rx_busy && i_baud_tick) begin
      if (rx_div == ovs - 5'h01) begin
        rx_div <= 5'h00;
        rx_bitn <= rx_bitn + 4'h1;
        rx_sh <= {rx_s2, rx_sh[10:1]};
        if (rx_bitn == nbits + {3'h0, par_en}) begin
          rx_busy <= 1'b0;
        end
      end else begin
        rx_div <= rx_div + 5'h01;
      end
    end
  end

  // Completed frame: data, ninth bit, parity check, stop check
  always_comb begin
    logic [10:0] al;
    logic [8:0] d;
    logic stp, pb;
    al = {rx_s2, rx_sh[10:1]} >> (4'hA - nbits - {3'h0, par_en}); // Last bit joins this cycle
    d = mask_bits(al[8:0], nbits);
    pb = al[nbits];
    stp = al[nbits + {3'h0, par_en}];
    rx_word = {!stp, par_en && (pb != (^d ^ ctrl_c[C_PM0])), d};
  end
  assign rx_push = rx_busy && i_baud_tick && (rx_div == ovs - 5'h01)
    && (rx_bitn == nbits + {3'h0, par_en} + 4'h1 - 4'h1)
    && !(mp_filter && !i_biphase_mode
         && !((nbits == 4'h9) ? rx_word[8] : !rx_word[10]));

  // Two-entry FIFO plus hold stage; flushed on receiver disable
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !ctrl_b[B_RECEIVER_ENABLE]) begin
      rx_count <= 2'h0;
      rx_rd_ptr <= 1'b0;
      rx_hold_full <= 1'b0;
      rx_hold <= 11'h000;
      dor_flag <= 1'b0;
      rx_fifo[0] <= 11'h000;
      rx_fifo[1] <= 11'h000;
    end else begin
      logic pop;
      logic [1:0] cnt;
      pop = rd_data && (rx_count != 2'h0);
      cnt = rx_count - {1'b0, pop};
      if (pop) begin
        rx_rd_ptr <= ~rx_rd_ptr;
        dor_flag <= 1'b0;
      end
      if (rx_hold_full && cnt != 2'h2) begin
        rx_fifo[rx_rd_ptr ^ pop ^ cnt[0]] <= rx_hold;
        rx_hold_full <= 1'b0;
        cnt = cnt + 2'h1;
      end
      // A new word follows the held one into the FIFO while room is left
      if (rx_push && cnt != 2'h2) begin
        rx_fifo[rx_rd_ptr ^ pop ^ cnt[0]] <= rx_word;
        cnt = cnt + 2'h1;
      end else if (rx_push) begin
        rx_hold <= rx_word;
        rx_hold_full <= 1'b1;
      end
      if (rx_start && rx_hold_full && rx_count == 2'h2) begin
        dor_flag <= 1'b1;
      end
      rx_count <= cnt;
    end
  end

  // Read mux, registered one cycle after the strobe
  always_ff @(posedge i_clk) begin
    logic [10:0] head;
    head = rx_fifo[rx_rd_ptr];
    if (i_sys_rst) begin
      o_rdata <= RST_DATA;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_DATA: o_rdata <= (rx_count != 2'h0) ? head[7:0] : RST_DATA;
        ADDR_CTRL_A: o_rdata <= {rx_count != 2'h0, txc_flag, !tx_buf_full,
          head[10] && rx_count != 2'h0, dor_flag, head[9] && rx_count != 2'h0,
          dbl_speed, mp_filter};
        ADDR_CTRL_B: o_rdata <= {ctrl_b[7:2], head[8], ctrl_b[B_TX8]};
        default: o_rdata <= ctrl_c;
      endcase
    end else begin
      o_rdata <= RST_DATA;
    end
  end

  // Interrupt requests gated by local and global enables
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rxc_irq <= 1'b0;
      o_txc_irq <= 1'b0;
      o_data_register_empty_flag_irq <= 1'b0;
    end else begin
      o_rxc_irq <= ctrl_b[B_RECEIVE_COMPLETE_IRQ_EN] && i_global_irq_en && (rx_count != 2'h0);
      o_txc_irq <= ctrl_b[B_TRANSMIT_COMPLETE_IRQ_EN] && i_global_irq_en && txc_flag;
      o_data_register_empty_flag_irq <= ctrl_b[B_DATA_EMPTY_IRQ_EN] && i_global_irq_en && !tx_buf_full;
    end
  end

  // Checks
  a_full_write_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_data && tx_buf_full && !tx_load) |=> (tx_buf == $past(tx_buf)))
    else $error("write accepted while buffer full");
  a_data_register_empty_flag_after_reset: assert property (@(posedge i_clk)
    $fell(i_sys_rst) |-> !tx_buf_full)
    else $error("buffer not empty after reset");
  a_txc_sets: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (tx_done && !tx_buf_full) |=> txc_flag)
    else $error("transmit complete not set");
  a_rx_flush: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !ctrl_b[B_RECEIVER_ENABLE] |=> (rx_count == 2'h0 && !dor_flag))
    else $error("receive buffer not flushed");
  a_fifo_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rx_count <= 2'h2)
    else $error("receive fifo overfilled");
  a_transmitter_enable_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (tx_state == USRI_TX_SHIFT) |=> tx_drive)
    else $error("pin released mid frame");
  a_rxc_irq_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rxc_irq |-> $past(ctrl_b[B_RECEIVE_COMPLETE_IRQ_EN] && i_global_irq_en && rx_count != 2'h0))
    else $error("receive interrupt without cause");
  a_load_shift: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tx_load |=> (tx_state == USRI_TX_SHIFT && !tx_buf_full))
    else $error("buffer not moved to shifter");
endmodule : usri_core

/* File: src/usri_pkg.sv */
// Package with register map, field positions and timing for the serial register layer
package usri_pkg;
  // Register offsets
  localparam logic [1:0] ADDR_DATA = 2'h0;
  localparam logic [1:0] ADDR_CTRL_A = 2'h1;
  localparam logic [1:0] ADDR_CTRL_B = 2'h2;
  localparam logic [1:0] ADDR_CTRL_C = 2'h3;
  // Control/status A fields
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_DATA_REGISTER_EMPTY_FLAG = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_UPE = 2;
  localparam int A_DBL = 1;
  localparam int A_MPF = 0;
  // Control B fields
  localparam int B_RECEIVE_COMPLETE_IRQ_EN = 7;
  localparam int B_TRANSMIT_COMPLETE_IRQ_EN = 6;
  localparam int B_DATA_EMPTY_IRQ_EN = 5;
  localparam int B_RECEIVER_ENABLE = 4;
  localparam int B_TRANSMITTER_ENABLE = 3;
  localparam int B_CSZ2 = 2;
  localparam int B_RX8 = 1;
  localparam int B_TX8 = 0;
  // Control C fields
  localparam int C_SYNC = 6;
  localparam int C_PM1 = 5;
  localparam int C_PM0 = 4;
  localparam int C_SBS = 3;
  localparam int C_CSZ1 = 2;
  localparam int C_CSZ0 = 1;
  localparam int C_POL = 0;
  // Reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_CTRL_C = 8'h06;
  localparam logic [7:0] WMASK_CTRL_C = 8'h7F;
  // Oversampling divisors
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  // Character size code for nine bits
  localparam logic [2:0] CSZ_NINE = 3'h7;
  // Transmit states
  typedef enum logic [1:0] {
    USRI_TX_IDLE = 2'b00,
    USRI_TX_SHIFT = 2'b01
  } usri_tx_state_t;
endpackage : usri_pkg

/* File: test/usri_remote.sv */
// Remote serial node model on the line side
`timescale 1ns/10ps
module usri_remote (
  // Clock
  input wire logic i_clk,
  // Serial line
  input wire logic i_txd,
  output logic o_rxd
);
  // Clocks per bit; halved by the bench for double speed
  int bit_clks = 16;
  // Bits heard after the last start bit, first in bit 0
  logic [9:0] heard = 10'h000;
  initial o_rxd = 1'b1;
  // Start bit, n bits least significant first, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    o_rxd <= 1'b0;
    repeat (bit_clks) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_rxd <= bits[i];
      repeat (bit_clks) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (2 * bit_clks) @(posedge i_clk);
  endtask : send
  // Samples each bit at its centre after a start edge
  initial begin
    forever begin
      @(negedge i_txd);
      repeat (bit_clks / 2) @(posedge i_clk);
      for (int i = 0; i < 10; i++) begin
        repeat (bit_clks) @(posedge i_clk);
        heard[i] = i_txd;
      end
    end
  end
endmodule : usri_remote

/* File: test/tb_top.sv */
// Self-checking bench for the serial register layer
`timescale 1ns/10ps
module tb_top
  import usri_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_global_irq_en = 1'b0;
  logic i_txc_irq_ack = 1'b0;
  logic i_biphase_mode = 1'b0;
  logic [7:0] o_rdata;
  logic i_rxd, o_txd, o_txd_oe, o_rxd_owned, o_rxc_irq, o_txc_irq, o_data_register_empty_flag_irq;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  // Clock at 25 ns period
  always #12.5 i_clk = ~i_clk;

  usri_core DUT (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_global_irq_en, .i_biphase_mode, .i_baud_tick(1'b1), .i_txc_irq_ack,
    .i_rxd, .o_txd, .o_txd_oe, .o_rxd_owned, .o_rxc_irq, .o_txc_irq, .o_data_register_empty_flag_irq);

  usri_remote remote (.i_clk, .i_txd(o_txd), .o_rxd(i_rxd));

  // Compares and counts
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    tick(1);
  endtask : wr
  // Register read, masked and compared
  task automatic rdc(input string what, input logic [1:0] a,
                     input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    i_addr <= a;
    i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    chk(what, {2'b00, d & m}, {2'b00, e});
    tick(1);
  endtask : rdc
  // Bounded wait for the transmit-complete request
  task automatic wait_txc();
    for (int n = 0; n < 1000 && o_txc_irq !== 1'b1; n++) tick(1);
    tick(20);
  endtask : wait_txc
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // Cuts a hang short
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    tick(12);
    i_sys_rst <= 1'b0;
    tick(1);
    rdc("a_rst", ADDR_CTRL_A, 8'hFF, 8'h20);
    rdc("b_rst", ADDR_CTRL_B, 8'hFF, 8'h00);
    rdc("c_rst", ADDR_CTRL_C, 8'hFF, 8'h06);
    rdc("rx_none", ADDR_DATA, 8'hFF, 8'h00);
    wr(ADDR_CTRL_B, 8'h20);
    tick(2);
    chk("data_register_empty_flag_irq0", {9'h0, o_data_register_empty_flag_irq}, 10'h0);
    i_global_irq_en <= 1'b1;
    tick(2);
    chk("data_register_empty_flag_irq1", {9'h0, o_data_register_empty_flag_irq}, 10'h1);
    // Full buffer drops a write; disable waits for the frame
    wr(ADDR_DATA, 8'h3C);
    rdc("data_register_empty_flag_full", ADDR_CTRL_A, 8'h20, 8'h00);
    wr(ADDR_DATA, 8'h81);
    wr(ADDR_CTRL_B, 8'h48);
    wr(ADDR_CTRL_B, 8'h40);
    tick(40);
    chk("oe_busy", {9'h0, o_txd_oe}, 10'h1);
    wait_txc();
    chk("frame8", remote.heard, 10'h33C);
    chk("oe_free", {9'h0, o_txd_oe}, 10'h0);
    chk("txc_irq", {9'h0, o_txc_irq}, 10'h1);
    i_txc_irq_ack <= 1'b1;
    tick(1);
    i_txc_irq_ack <= 1'b0;
    tick(2);
    chk("txc_ack", {9'h0, o_txc_irq}, 10'h0);
    // Five bits, even parity, two stops: upper bits stay off the line
    wr(ADDR_CTRL_C, 8'h28);
    wr(ADDR_CTRL_B, 8'h48);
    wr(ADDR_DATA, 8'hE0);
    tick(136);
    chk("two_stops", {9'h0, o_txc_irq}, 10'h0);
    wait_txc();
    chk("frame5p", remote.heard, 10'h3C0);
    wr(ADDR_CTRL_A, 8'h40);
    rdc("txc_w1c", ADDR_CTRL_A, 8'h40, 8'h00);
    // Receive queue order and drain
    wr(ADDR_CTRL_C, 8'h06);
    wr(ADDR_CTRL_B, 8'h90);
    tick(2);
    chk("rx_own", {9'h0, o_rxd_owned}, 10'h1);
    remote.send(12'h1A7, 9);
    remote.send(12'h15B, 9);
    chk("rxc_irq", {9'h0, o_rxc_irq}, 10'h1);
    rdc("rxc_set", ADDR_CTRL_A, 8'h80, 8'h80);
    rdc("rx_1st", ADDR_DATA, 8'hFF, 8'hA7);
    rdc("rx_2nd", ADDR_DATA, 8'hFF, 8'h5B);
    rdc("rxc_clr", ADDR_CTRL_A, 8'h80, 8'h00);
    chk("rxc_irq0", {9'h0, o_rxc_irq}, 10'h0);
    remote.send(12'h011, 9);
    rdc("fe_set", ADDR_CTRL_A, 8'h10, 8'h10);
    rdc("rx_fe", ADDR_DATA, 8'hFF, 8'h11);
    rdc("fe_clr", ADDR_CTRL_A, 8'h10, 8'h00);
    wr(ADDR_CTRL_C, 8'h04);
    remote.send(12'h0FF, 8);
    rdc("rx7", ADDR_DATA, 8'hFF, 8'h7F);
    // Even parity fails, odd parity passes on the same frame
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CTRL_C, i ? 8'h36 : 8'h26);
      remote.send(12'h201, 10);
      rdc("upe", ADDR_CTRL_A, 8'h04, i ? 8'h00 : 8'h04);
      rdc("rx_par", ADDR_DATA, 8'hFF, 8'h01);
    end
    wr(ADDR_CTRL_C, 8'h06);
    wr(ADDR_CTRL_A, 8'h02);
    remote.bit_clks = 8;
    remote.send(12'h1C3, 9);
    remote.bit_clks = 16;
    rdc("rx_dbl", ADDR_DATA, 8'hFF, 8'hC3);
    wr(ADDR_CTRL_A, 8'h00);
    // Overrun, then disable flushes what is left
    for (int i = 0; i < 4; i++) remote.send(12'h100 | 12'(i), 9);
    rdc("dor_set", ADDR_CTRL_A, 8'h08, 8'h08);
    rdc("rx_ovr", ADDR_DATA, 8'hFF, 8'h00);
    rdc("dor_clr", ADDR_CTRL_A, 8'h08, 8'h00);
    wr(ADDR_CTRL_B, 8'h00);
    rdc("flush", ADDR_CTRL_A, 8'h9C, 8'h00);
    rdc("rx_flush", ADDR_DATA, 8'hFF, 8'h00);
    chk("rx_rel", {9'h0, o_rxd_owned}, 10'h0);
    // Nine-bit frames with filtering: only the address frame lands
    wr(ADDR_CTRL_B, 8'h94);
    wr(ADDR_CTRL_A, 8'h01);
    remote.send(12'h222, 10);
    remote.send(12'h333, 10);
    rdc("ninth", ADDR_CTRL_B, 8'h02, 8'h02);
    rdc("rx_addr", ADDR_DATA, 8'hFF, 8'h33);
    rdc("filtered", ADDR_CTRL_A, 8'h80, 8'h00);
    // Biphase: size code and filter ignored, so an eight-bit data frame lands
    i_biphase_mode <= 1'b1;
    remote.send(12'h0A5, 9);
    rdc("bi_data", ADDR_DATA, 8'hFF, 8'hA5);
    i_biphase_mode <= 1'b0;
    // Nine-bit transmit: ninth bit goes in before the low byte
    wr(ADDR_CTRL_B, 8'h4D);
    wr(ADDR_DATA, 8'h5A);
    wait_txc();
    chk("frame9", remote.heard, 10'h35A);
    wrap_up();
  end
endmodule : tb_top
